// ===== upt_uart.sv
// Full-duplex serial port with flow control and USB-line pass-through.
// Assumes one 100 MHz clock; pin inputs are asynchronous to it.
`timescale 1ns/1ps
// Summary of operation
// - The port sends on its transmit line and receives on its receive line together, with a flow-control input and output.
// - A firmware-set divider gives bit rates spanning 300 bps to 4608 Kbps.
// - With flow control on, a character starts only while the clear-to-send input is asserted.
// - The ready-to-receive output is asserted whenever the receiver can take another character.
// - In pass-through mode the USB transceiver is switched off and the data pair just carries the serial lines.
// - In pass-through mode transmit drives D- and receive is taken from D+.
// - Pass-through lines go either to the parallel programmable interface pins or to two general-purpose pins.
// - In pass-through mode the bit rate is held at or below 9600 bps.
// - Pass-through mode carries plain serial traffic over the data pair whenever firmware enables it.
module upt_uart
  import upt_pkg::*;
#(
  parameter int WIDTH = DATA_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [DIV_W-1:0] baud_div,
  input wire logic flow_en,
  input wire logic pass_en,
  input wire logic pass_route_gpio,
  input wire logic [WIDTH-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [WIDTH-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_frame_err,
  output logic tx_pin,
  input wire logic rx_pin,
  input wire logic cts_pin,
  output logic rts_pin,
  output logic usb_xcvr_en,
  output logic dm_out,
  output logic dm_oe,
  input wire logic dp_in,
  output logic ppi_tx_out,
  input wire logic ppi_rx_in,
  output logic gpio_tx_out,
  input wire logic gpio_rx_in,
  output logic tx_busy
);
  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] rx_s;
  logic [2:0] cts_s;
  logic rx_in;
  logic next_rx_in;
  logic cts_in;
  logic next_cts_in;
  logic raw_rx;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_comb begin
    if (pass_en && pass_route_gpio) begin
      raw_rx = gpio_rx_in;
    end else if (pass_en) begin
      raw_rx = ppi_rx_in;
    end else begin
      raw_rx = rx_pin;
    end
    if (pass_en) begin
      raw_rx = raw_rx & dp_in;
    end
    // A level counts once the second and third stages agree
    next_rx_in = (rx_s[2] == rx_s[1]) ? rx_s[1] : rx_in;
    next_cts_in = (cts_s[2] == cts_s[1]) ? cts_s[1] : cts_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s <= 3'h7;
      cts_s <= 3'h0;
      rx_in <= LINE_IDLE;
      cts_in <= 1'b0;
    end else if (ce) begin
      rx_s <= {rx_s[1:0], raw_rx};
      cts_s <= {cts_s[1:0], cts_pin};
      rx_in <= next_rx_in;
      cts_in <= next_cts_in;
    end
  end

  // ==========================================================
  // Bit-rate divider
  logic [DIV_W-1:0] div_eff;
  always_comb begin
    div_eff = (baud_div == DIV_ZERO) ? DIV_ONE : baud_div;
    if (pass_en && div_eff < PASS_DIV_MIN) begin
      div_eff = PASS_DIV_MIN;
    end
  end

  // ==========================================================
  // Transmit queue and shifter
  localparam int FILL_W = $clog2(DEPTH) + 1;
  logic [WIDTH-1:0] q_data;
  logic q_valid;
  logic tq_pop;
  logic q_push;
  logic [FILL_W-1:0] q_fill;
  logic [FILL_W-1:0] next_q_fill;
  upt_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data(tx_data),
    .in_valid(q_push),
    .in_ready(),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(tq_pop)
  );

  // Own fill count lets tx_ready be a flop that never admits an extra word
  always_comb begin
    q_push = tx_valid && tx_ready;
    next_q_fill = q_fill;
    if (q_push && !tq_pop) begin
      next_q_fill = q_fill + 1'b1;
    end else if (tq_pop && !q_push) begin
      next_q_fill = q_fill - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_fill <= '0;
    end else if (ce) begin
      q_fill <= next_q_fill;
    end
  end

  upt_state_type ts;
  upt_state_type next_ts;
  logic [DIV_W-1:0] tcnt;
  logic [DIV_W-1:0] next_tcnt;
  logic [3:0] tbit;
  logic [3:0] next_tbit;
  logic [WIDTH-1:0] tsh;
  logic [WIDTH-1:0] next_tsh;
  logic tline;
  logic next_tline;
  logic tick_t;

  always_comb begin
    next_ts = ts;
    next_tcnt = tcnt;
    next_tbit = tbit;
    next_tsh = tsh;
    next_tline = tline;
    tq_pop = 1'b0;
    tick_t = tcnt >= div_eff - DIV_ONE;
    if (ts != UPT_IDLE) begin
      next_tcnt = tick_t ? DIV_ZERO : tcnt + DIV_ONE;
    end
    case (ts)
      UPT_IDLE: begin
        next_tline = LINE_IDLE;
        // Flow check only at character start, never mid-frame
        if (q_valid && (!flow_en || cts_in)) begin
          tq_pop = 1'b1;
          next_tsh = q_data;
          next_tline = START_LEVEL;
          next_tcnt = DIV_ZERO;
          next_ts = UPT_START;
        end
      end
      UPT_START: begin
        if (tick_t) begin
          next_tline = tsh[0];
          next_tbit = BIT_ZERO;
          next_ts = UPT_DATA;
        end
      end
      UPT_DATA: begin
        if (tick_t) begin
          if (tbit == 4'(WIDTH - 1)) begin
            next_tline = STOP_LEVEL;
            next_ts = UPT_STOP;
          end else begin
            next_tsh = tsh >> 1;
            next_tline = tsh[1];
            next_tbit = tbit + 4'h1;
          end
        end
      end
      UPT_STOP: begin
        if (tick_t) begin
          next_ts = UPT_IDLE;
        end
      end
      default: next_ts = UPT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts <= UPT_IDLE;
      tcnt <= DIV_ZERO;
      tbit <= BIT_ZERO;
      tsh <= '0;
      tline <= LINE_IDLE;
    end else if (ce) begin
      ts <= next_ts;
      tcnt <= next_tcnt;
      tbit <= next_tbit;
      tsh <= next_tsh;
      tline <= next_tline;
    end
  end

  // ==========================================================
  // Receiver: samples each bit at its middle
  upt_state_type rs;
  upt_state_type next_rs;
  logic [DIV_W-1:0] rcnt;
  logic [DIV_W-1:0] next_rcnt;
  logic [3:0] rbit;
  logic [3:0] next_rbit;
  logic [WIDTH-1:0] rsh;
  logic [WIDTH-1:0] next_rsh;
  logic [WIDTH-1:0] next_rx_data;
  logic next_rx_valid;
  logic next_ferr;
  logic tick_r;

  always_comb begin
    next_rs = rs;
    next_rbit = rbit;
    next_rsh = rsh;
    next_rx_data = rx_data;
    next_rx_valid = rx_valid && !rx_ready;
    next_ferr = rx_frame_err;
    tick_r = rcnt >= div_eff - DIV_ONE;
    next_rcnt = tick_r ? DIV_ZERO : rcnt + DIV_ONE;
    case (rs)
      UPT_IDLE: begin
        next_rcnt = DIV_ZERO;
        if (rx_in == START_LEVEL) begin
          next_rcnt = div_eff >> 1;
          next_rs = UPT_START;
        end
      end
      UPT_START: begin
        if (tick_r) begin
          next_rbit = BIT_ZERO;
          next_rs = (rx_in == START_LEVEL) ? UPT_DATA : UPT_IDLE;
        end
      end
      UPT_DATA: begin
        if (tick_r) begin
          next_rsh = {rx_in, rsh[WIDTH-1:1]};
          next_rbit = rbit + 4'h1;
          if (rbit == 4'(WIDTH - 1)) begin
            next_rs = UPT_STOP;
          end
        end
      end
      UPT_STOP: begin
        if (tick_r) begin
          next_rs = UPT_IDLE;
          next_ferr = rx_in != STOP_LEVEL;
          // Held word is replaced if the consumer has not taken it
          next_rx_data = rsh;
          next_rx_valid = 1'b1;
        end
      end
      default: next_rs = UPT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs <= UPT_IDLE;
      rcnt <= DIV_ZERO;
      rbit <= BIT_ZERO;
      rsh <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
    end else if (ce) begin
      rs <= next_rs;
      rcnt <= next_rcnt;
      rbit <= next_rbit;
      rsh <= next_rsh;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_frame_err <= next_ferr;
    end
  end

  // ==========================================================
  // Registered pin outputs
  logic next_rts;
  always_comb begin
    next_rts = !flow_en || !next_rx_valid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin <= LINE_IDLE;
      rts_pin <= 1'b0;
      usb_xcvr_en <= 1'b1;
      dm_out <= LINE_IDLE;
      dm_oe <= 1'b0;
      ppi_tx_out <= LINE_IDLE;
      gpio_tx_out <= LINE_IDLE;
      tx_ready <= 1'b0;
      tx_busy <= 1'b0;
    end else if (ce) begin
      tx_pin <= pass_en ? LINE_IDLE : next_tline;
      rts_pin <= next_rts;
      usb_xcvr_en <= !pass_en;
      dm_out <= next_tline;
      dm_oe <= pass_en;
      ppi_tx_out <= (pass_en && !pass_route_gpio) ? next_tline : LINE_IDLE;
      gpio_tx_out <= (pass_en && pass_route_gpio) ? next_tline : LINE_IDLE;
      tx_ready <= next_q_fill != FILL_W'(DEPTH);
      tx_busy <= next_ts != UPT_IDLE || q_valid;
    end
  end
endmodule

// ===== upt_pkg.sv
// Package for the serial port with USB-line pass-through.
// Assumes a single 100 MHz system clock shared by every user.
package upt_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_MIN_BPS = 300;
  localparam int unsigned BAUD_MAX_BPS = 4_608_000;
  localparam int unsigned PASS_MAX_BPS = 9600;
  localparam int unsigned DIV_W = 20;
  // Least divider allowed in pass-through: rounds up to keep rate <= limit
  localparam logic [DIV_W-1:0] PASS_DIV_MIN =
    DIV_W'((CLK_HZ + PASS_MAX_BPS - 1) / PASS_MAX_BPS);
  localparam logic [DIV_W-1:0] DIV_DEFAULT =
    DIV_W'(CLK_HZ / 115_200);
  localparam logic [DIV_W-1:0] DIV_ONE = 20'h00001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 20'h00000;
  // ==========================================================
  // Framing
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  localparam int unsigned FIFO_DEPTH = 16;
  // ==========================================================
  // Serial state machine
  typedef enum logic [1:0] {
    UPT_IDLE = 2'b00,
    UPT_START = 2'b01,
    UPT_DATA = 2'b10,
    UPT_STOP = 2'b11
  } upt_state_type;
endpackage

// ===== upt_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, the synchronised reset and a shared clock enable.
`timescale 1ns/1ps
module upt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb begin
    in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; empty flag guards the contents
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== upt_uart_monitor.sv
// Checker for the serial port with USB-line pass-through.
// Assumes it is bound to upt_uart and sees only its ports.
`timescale 1ns/1ps
module upt_uart_monitor
  import upt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [DIV_W-1:0] baud_div,
  input wire logic flow_en,
  input wire logic pass_en,
  input wire logic pass_route_gpio,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_pin,
  input wire logic cts_pin,
  input wire logic rts_pin,
  input wire logic usb_xcvr_en,
  input wire logic dm_out,
  input wire logic dm_oe,
  input wire logic ppi_tx_out,
  input wire logic gpio_tx_out
);
  // ==========================================================
  // Helper counters
  logic [2:0] up, next_up;
  logic [23:0] hi_cnt, next_hi, ten_bits;
  logic [3:0] cl_cnt, next_cl;
  assign ten_bits = 24'(baud_div) * 24'h00000A;
  always_comb begin
    next_up = (up == 3'h7) ? up : up + 3'h1;
    next_hi = !tx_pin ? 24'h0 : ((&hi_cnt) ? hi_cnt : hi_cnt + 24'h1);
    next_cl = cts_pin ? 4'h0 : ((&cl_cnt) ? cl_cnt : cl_cnt + 4'h1);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up <= 3'h0;
      hi_cnt <= 24'h0;
      cl_cnt <= 4'h0;
    end else begin
      up <= next_up;
      hi_cnt <= next_hi;
      cl_cnt <= next_cl;
    end
  end
  // ==========================================================
  // Properties
  // Outputs settle a few edges after reset release
  default clocking @(posedge clk); endclocking
  default disable iff (up != 3'h7);
  sequence pass_on_s;
    pass_en [*3];
  endsequence
  // Line idle for a whole frame while clear-to-send has been low
  sequence quiet_s;
    flow_en && !pass_en && baud_div != 20'h0 && cl_cnt >= 4'h6
      && hi_cnt >= ten_bits;
  endsequence
  xcvr_off_a: assert property (pass_on_s |-> !usb_xcvr_en)
    else $error("transceiver on in pass-through");
  pass_drive_a: assert property (pass_on_s |-> dm_oe && tx_pin)
    else $error("D- not driven in pass-through");
  gpio_route_a: assert property ((pass_en && pass_route_gpio) [*3]
    |-> gpio_tx_out == dm_out)
    else $error("gpio route differs from D-");
  ppi_route_a: assert property ((pass_en && !pass_route_gpio) [*3]
    |-> ppi_tx_out == dm_out)
    else $error("parallel route differs from D-");
  cts_hold_a: assert property (quiet_s |=> tx_pin)
    else $error("start bit sent without clear-to-send");
  rts_full_a: assert property ((flow_en && rx_valid && !rx_ready) [*3]
    |-> !rts_pin)
    else $error("ready-to-receive high with unread word");
  rts_noflow_a: assert property ((!flow_en) [*3] |-> rts_pin)
    else $error("ready-to-receive low with flow control off");
  rx_keep_a: assert property (rx_valid && !rx_ready |=> rx_valid)
    else $error("received word lost before taken");
endmodule

bind upt_uart upt_uart_monitor i_mon (.clk, .nrst, .baud_div, .flow_en,
  .pass_en, .pass_route_gpio, .rx_valid, .rx_ready, .tx_pin, .cts_pin,
  .rts_pin, .usb_xcvr_en, .dm_out, .dm_oe, .ppi_tx_out, .gpio_tx_out);

// ===== upt_host_model.sv
// Behavioural model of the host processor's serial port.
// Assumes the bench sets the divider and calls send by hierarchy.
`timescale 1ns/1ps
module upt_host_model (
  input wire logic clk,
  input wire logic [19:0] div,
  input wire logic line_in,
  input wire logic rts_pin,
  output logic line_out,
  output logic [8:0] got,
  output logic got_stb
);
  int i;
  logic [8:0] sh;
  initial begin
    line_out = 1'b1;
    got = 9'h000;
    got_stb = 1'b0;
  end
  // ==========================================================
  // Transmit: waits for ready-to-receive, one frame
  task automatic send(input logic [7:0] d, input logic bad);
    int k;
    k = 0;
    while (rts_pin !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    line_out = 1'b0;
    repeat (div) @(negedge clk);
    for (int b = 0; b < 8; b++) begin
      line_out = d[b];
      repeat (div) @(negedge clk);
    end
    // A bad stop is low only long enough to be seen at its middle
    line_out = !bad;
    repeat (bad ? div - div / 4 : div) @(negedge clk);
    line_out = 1'b1;
    repeat (div / 4) @(negedge clk);
  endtask
  // ==========================================================
  // Receive: mid-bit sampling, stop bit kept in bit 8
  always begin
    @(negedge line_in);
    repeat (div / 2) @(posedge clk);
    if (line_in === 1'b0) begin
      for (i = 0; i < 9; i++) begin
        repeat (div) @(posedge clk);
        sh[i] = line_in;
      end
      got <= sh;
      got_stb <= 1'b1;
      @(posedge clk);
      got_stb <= 1'b0;
    end
  end
endmodule

// ===== tb.sv
// Self-checking bench for the serial port with pass-through.
// Assumes upt_pkg, upt_fifo, upt_uart and the host model are compiled.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %0h want %0h", $time, (a), (b)); end end
module tb
  import upt_pkg::*;
;
  logic clk, nrst, flow_en, pass_en, pass_route_gpio, tx_valid, rx_ready;
  logic cts_pin, rx_pin, tx_ready, rx_valid, rx_frame_err, tx_pin, rts_pin;
  logic usb_xcvr_en, dm_out, dm_oe, ppi_tx_out, gpio_tx_out, tx_busy;
  logic got_stb;
  logic [8:0] got, exp_t, exp_r;
  logic [DIV_W-1:0] baud_div;
  logic [7:0] tx_data, rx_data;
  logic [DIV_W-1:0] rates [2] = '{20'h00016, 20'h00008};
  logic [8:0] tx_q [$];
  logic [8:0] rx_q [$];
  int num_checks, failures, cyc, n, k;
  upt_uart i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .baud_div(baud_div),
    .flow_en(flow_en), .pass_en(pass_en), .pass_route_gpio(pass_route_gpio),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_frame_err(rx_frame_err), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .cts_pin(cts_pin), .rts_pin(rts_pin), .usb_xcvr_en(usb_xcvr_en),
    .dm_out(dm_out), .dm_oe(dm_oe), .dp_in(1'b1), .ppi_tx_out(ppi_tx_out),
    .ppi_rx_in(1'b1), .gpio_tx_out(gpio_tx_out), .gpio_rx_in(1'b1),
    .tx_busy(tx_busy));
  upt_host_model i_host (.clk(clk), .div(baud_div), .line_in(tx_pin),
    .rts_pin(rts_pin), .line_out(rx_pin), .got(got), .got_stb(got_stb));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task print_verdict();
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Sets valid on every call and leaves it high; the caller drops it after the last write
  task put(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    tx_q.push_back({1'b1, d});
    @(negedge clk);
  endtask
  task hsend(input logic [7:0] d, input logic bad);
    rx_q.push_back({bad, d});
    i_host.send(d, bad);
  endtask
  task drain();
    k = 0;
    while (tx_busy !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
  endtask
  // ==========================================================
  // Result watcher and hang limit
  always @(posedge clk) begin
    // Pop once into a temporary: the macro reads its second argument twice
    if (got_stb === 1'b1) begin
      exp_t = tx_q.pop_front();
      `CHK(got, exp_t)
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      exp_r = rx_q.pop_front();
      `CHK(rx_data, exp_r[7:0])
      `CHK(rx_frame_err, exp_r[8])
    end
    cyc++;
    if (cyc == 40000) begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(70));
    {nrst, flow_en, pass_en, pass_route_gpio, tx_valid, cts_pin} = 6'h00;
    rx_ready = 1'b1;
    baud_div = 20'h00008;
    tx_data = 8'h00;
    repeat (8) @(negedge clk);
    `CHK({tx_pin, rts_pin, usb_xcvr_en, dm_oe, tx_ready}, 5'h14)
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    // Both directions at once, clear-to-send low but ignored
    foreach (rates[r]) begin
      baud_div = rates[r];
      fork
        begin
          for (int j = 0; j < 3; j++) put(8'($urandom));
          tx_valid = 1'b0;
        end
        for (int j = 0; j < 3; j++) hsend(8'($urandom), 1'b0);
      join
      drain();
    end
    `CHK(rts_pin, 1'b1)
    // Far side stalls while the buffer fills
    flow_en = 1'b1;
    n = 0;
    while (tx_ready === 1'b1 && n < 20) begin
      put(8'($urandom));
      n++;
    end
    tx_valid = 1'b0;
    `CHK(n, FIFO_DEPTH)
    repeat (200) @(negedge clk);
    `CHK(tx_pin, 1'b1)
    cts_pin = 1'b1;
    drain();
    `CHK(tx_q.size(), 0)
    rx_ready = 1'b0;
    hsend(8'($urandom), 1'b1);
    repeat (4) @(negedge clk);
    `CHK({rx_valid, rts_pin}, 2'b10)
    rx_ready = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(rts_pin, 1'b1)
    // Pass-through: rate clamp and both routes
    {flow_en, pass_en, pass_route_gpio} = 3'b011;
    repeat (4) @(negedge clk);
    `CHK({usb_xcvr_en, dm_oe, tx_pin}, 3'b011)
    put(8'h01);
    tx_valid = 1'b0;
    void'(tx_q.pop_back());
    k = 0;
    while (dm_out !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    `CHK(dm_out, 1'b0)
    `CHK({gpio_tx_out, ppi_tx_out}, 2'b01)
    // Switch route inside the start bit so the low level must follow it
    pass_route_gpio = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({gpio_tx_out, ppi_tx_out}, 2'b10)
    n = 2;
    while (dm_out === 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    `CHK(DIV_W'(n), PASS_DIV_MIN)
    `CHK({dm_out, ppi_tx_out}, 2'b11)
    print_verdict();
  end
endmodule
